// *** core/csc_consts.vh ***
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH
`define CSC_OFF_EVENT 8'h80
`define CSC_OFF_MASK 8'h84
`define CSC_OFF_PRESENT 8'h88
`define CSC_OFF_FORCE 8'h8C
`define CSC_BIT_INT 15
`define CSC_BIT_WAKE_SUM 14
`define CSC_BIT_WAKE 4
`define CSC_MAIN_BIT_A 0
`define CSC_MAIN_BIT_B 1
`define CSC_PS_D0 2'h0
`define CSC_RST_BIT 1'b0
`define CSC_RST_WORD 32'h00000000
`endif

// *** core/csc_regs.v ***
`timescale 1ns/1ps
`include "csc_consts.vh"
module csc_regs #(
  parameter ADDR_W = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire func_rst,
  input wire acc_req,
  input wire acc_mem,
  input wire acc_wr,
  input wire [ADDR_W-1:0] acc_addr,
  input wire [31:0] acc_wdata,
  output reg [31:0] acc_rdata,
  output reg acc_ack,
  input wire status_changed_option,
  input wire [1:0] main_status_bits,
  input wire [1:0] power_state,
  input wire wake_event,
  input wire pme_status_clr,
  input wire pme_status,
  input wire pme_enable,
  output reg int_n,
  output reg wake_out,
  output wire regs_valid
);

  // Power-up reset is resetn; func_rst is the hardware/software reset
  reg armed_reg;
  reg armed_next;
  reg ev_int_reg;
  reg ev_int_next;
  reg ev_wake_reg;
  reg ev_wake_next;
  reg mk_int_reg;
  reg mk_int_next;
  reg mk_sum_reg;
  reg mk_sum_next;
  reg mk_wake_reg;
  reg mk_wake_next;
  reg ps_int_reg;
  reg ps_int_next;
  reg ps_wake_reg;
  reg ps_wake_next;
  reg [31:0] rdata_next;
  reg int_n_next;
  reg wake_next;

  wire mem_acc;
  wire wr_acc;
  wire rd_acc;
  wire hit_event;
  wire hit_mask;
  wire hit_present;
  wire hit_force;
  wire wr_event;
  wire wr_mask;
  wire int_pending;
  wire ev_wake_clr;
  wire valid;

  assign mem_acc = acc_req & acc_mem;
  assign wr_acc = mem_acc & acc_wr;
  assign rd_acc = mem_acc & ~acc_wr;

  assign hit_event = (acc_addr == `CSC_OFF_EVENT);
  assign hit_mask = (acc_addr == `CSC_OFF_MASK);
  assign hit_present = (acc_addr == `CSC_OFF_PRESENT);
  assign hit_force = (acc_addr == `CSC_OFF_FORCE);

  assign wr_event = wr_acc & hit_event;
  assign wr_mask = wr_acc & hit_mask;

  // Pending interrupt from the main status bits, only in D0
  assign int_pending = (main_status_bits[`CSC_MAIN_BIT_A] |
                        main_status_bits[`CSC_MAIN_BIT_B]) &
                       (power_state == `CSC_PS_D0);

  // Either a write-one or the status clear removes the wake event
  assign ev_wake_clr = (wr_event & acc_wdata[`CSC_BIT_WAKE]) |
                       pme_status_clr;

  assign valid = status_changed_option & armed_reg;
  assign regs_valid = valid;

  always @* begin
    armed_next = armed_reg;
    if (wr_event | wr_mask) begin
      armed_next = 1'b1;
    end
  end

  always @* begin
    ev_int_next = ev_int_reg;
    if (wr_event & acc_wdata[`CSC_BIT_INT]) begin
      ev_int_next = 1'b0;
    end
    if (func_rst) begin
      ev_int_next = `CSC_RST_BIT;
    end
    // Set wins so an interrupt in the clearing cycle is kept
    if (int_pending) begin
      ev_int_next = 1'b1;
    end
  end

  always @* begin
    ev_wake_next = ev_wake_reg;
    // Hardware and software reset deliberately leave this bit alone
    if (ev_wake_clr) begin
      ev_wake_next = 1'b0;
    end
    if (wake_event) begin
      ev_wake_next = 1'b1;
    end
  end

  always @* begin
    mk_int_next = mk_int_reg;
    mk_sum_next = mk_sum_reg;
    mk_wake_next = mk_wake_reg;
    // Plain write: a clear-only mask could never be enabled
    if (wr_mask) begin
      mk_int_next = acc_wdata[`CSC_BIT_INT];
      mk_sum_next = acc_wdata[`CSC_BIT_WAKE_SUM];
      mk_wake_next = acc_wdata[`CSC_BIT_WAKE];
    end
    // Wake enables survive func_rst
    if (func_rst) begin
      mk_int_next = `CSC_RST_BIT;
    end
  end

  always @* begin
    ps_int_next = int_pending &
                  (mk_int_reg | ~status_changed_option);
  end

  always @* begin
    ps_wake_next = ps_wake_reg;
    if (ev_wake_clr) begin
      ps_wake_next = 1'b0;
    end
    if (wake_event) begin
      ps_wake_next = 1'b1;
    end
  end

  always @* begin
    if (valid) begin
      int_n_next = ~(int_pending & mk_int_reg);
    end else begin
      int_n_next = ~int_pending;
    end
  end

  always @* begin
    // Power-management path is outside the mask; software clears its enable
    wake_next = pme_enable & pme_status;
    if (valid & mk_sum_reg & mk_wake_reg & ev_wake_reg) begin
      wake_next = 1'b1;
    end
  end

  always @* begin
    // Reserved bits and the write-only force register read as zero
    rdata_next = `CSC_RST_WORD;
    if (hit_event) begin
      rdata_next[`CSC_BIT_INT] = ev_int_reg;
      rdata_next[`CSC_BIT_WAKE] = ev_wake_reg;
    end
    if (hit_mask) begin
      rdata_next[`CSC_BIT_INT] = mk_int_reg;
      rdata_next[`CSC_BIT_WAKE_SUM] = mk_sum_reg;
      rdata_next[`CSC_BIT_WAKE] = mk_wake_reg;
    end
    if (hit_present) begin
      rdata_next[`CSC_BIT_INT] = ps_int_reg;
      rdata_next[`CSC_BIT_WAKE] = ps_wake_reg;
    end
    if (hit_force) begin
      rdata_next = `CSC_RST_WORD;
    end
  end

  // Writes to the present-state offset are ignored; ps_wake_reg is cleared only through ev_wake_clr or the resetn power-up reset
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ps_int_reg <= `CSC_RST_BIT;
      ps_wake_reg <= `CSC_RST_BIT;
    end else if (ce) begin
      ps_int_reg <= ps_int_next;
      ps_wake_reg <= ps_wake_next;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_reg <= `CSC_RST_BIT;
      ev_int_reg <= `CSC_RST_BIT;
      ev_wake_reg <= `CSC_RST_BIT;
    end else if (ce) begin
      armed_reg <= armed_next;
      ev_int_reg <= ev_int_next;
      ev_wake_reg <= ev_wake_next;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mk_int_reg <= `CSC_RST_BIT;
      mk_sum_reg <= `CSC_RST_BIT;
      mk_wake_reg <= `CSC_RST_BIT;
    end else if (ce) begin
      mk_int_reg <= mk_int_next;
      mk_sum_reg <= mk_sum_next;
      mk_wake_reg <= mk_wake_next;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_n <= 1'b1;
      wake_out <= 1'b0;
    end else if (ce) begin
      int_n <= int_n_next;
      wake_out <= wake_next;
    end
  end

  // I/O-space accesses get no answer at all
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc_ack <= 1'b0;
      acc_rdata <= `CSC_RST_WORD;
    end else if (ce) begin
      acc_ack <= mem_acc;
      if (rd_acc) begin
        acc_rdata <= rdata_next;
      end
    end
  end

endmodule // csc_regs

// *** tb/csc_regs_asserts.sv ***
`timescale 1ns/1ps
module csc_regs_asserts #(
  parameter ADDR_W = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire func_rst,
  input wire acc_req,
  input wire acc_mem,
  input wire acc_wr,
  input wire [ADDR_W-1:0] acc_addr,
  input wire [31:0] acc_wdata,
  input wire [31:0] acc_rdata,
  input wire acc_ack,
  input wire status_changed_option,
  input wire [1:0] main_status_bits,
  input wire [1:0] power_state,
  input wire wake_event,
  input wire pme_status_clr,
  input wire pme_status,
  input wire pme_enable,
  input wire int_n,
  input wire wake_out,
  input wire regs_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire pend = (|main_status_bits) && power_state == 2'h0;
  wire acc = ce && acc_req && acc_mem;
  // Attempts launched while reset is still sampled low would check reset-held outputs
  mem_ack_a: assert property (resetn && acc |=> acc_ack) else $error("no ack");
  io_ignore_a: assert property (ce && acc_req && !acc_mem |=> !acc_ack)
    else $error("io ack");
  int_bypass_a: assert property (resetn && ce && !regs_valid |=> int_n == !$past(pend))
    else $error("int pin");
  int_idle_a: assert property (ce && !pend |=> int_n) else $error("int idle");
  wake_bypass_a: assert property (resetn && ce && !regs_valid |=>
    wake_out == $past(pme_enable && pme_status)) else $error("wake pin");
  pme_wake_a: assert property (resetn && ce && pme_enable && pme_status |=> wake_out)
    else $error("pme wake");
  valid_opt_a: assert property (!status_changed_option |-> !regs_valid)
    else $error("valid");
  armed_hold_a: assert property ($past(regs_valid) && status_changed_option |-> regs_valid)
    else $error("armed lost");
  armed_set_a: assert property (acc && acc_wr && (acc_addr == 8'h80 || acc_addr == 8'h84)
    ##1 status_changed_option |-> regs_valid) else $error("armed");
endmodule // csc_regs_asserts

// *** tb/csc_host.sv ***
`timescale 1ns/1ps
module csc_host (
  input wire ref_clk,
  output reg acc_req = 1'b0,
  output reg acc_mem = 1'b0,
  output reg acc_wr = 1'b0,
  output reg [7:0] acc_addr = 8'h00,
  output reg [31:0] acc_wdata = 32'h00000000,
  input wire [31:0] acc_rdata,
  input wire acc_ack
);
  task xfer(input m, input w, input [7:0] a, input [31:0] d, output [31:0] rd, output ak);
    begin
      @(posedge ref_clk);
      acc_req <= 1'b1;
      acc_mem <= m;
      acc_wr <= w;
      acc_addr <= a;
      acc_wdata <= d & 32'h0000C010;
      @(posedge ref_clk);
      acc_req <= 1'b0;
      // Inverted after release so stale data cannot pass
      acc_wdata <= ~d;
      #1;
      rd = acc_rdata;
      ak = acc_ack;
    end
  endtask
endmodule // csc_host

// *** tb/csc_regs_tb.sv ***
`timescale 1ns/1ps
module csc_regs_tb;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  reg func_rst = 1'b0;
  reg status_changed_option = 1'b0;
  reg [1:0] main_status_bits = 2'h0;
  reg [1:0] power_state = 2'h0;
  reg wake_event = 1'b0;
  reg pme_status_clr = 1'b0;
  reg pme_status = 1'b0;
  reg pme_enable = 1'b0;
  wire acc_req, acc_mem, acc_wr, acc_ack, int_n, wake_out, regs_valid;
  wire [7:0] acc_addr;
  wire [31:0] acc_wdata, acc_rdata;
  integer failures = 0;
  integer num_checks = 0;
  integer i;
  reg e15, e4, m15, m14, m4, p15, p4, armed, pend, w0, w1, ak, mem;
  reg [31:0] rexp, rd;
  csc_regs DUT (.ce(1'b1), .*);
  csc_host host (.*);
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {e15, e4, m15, m14, m4, p15, p4, armed} <= 8'h00;
    end else begin
      pend = (|main_status_bits) && power_state == 2'h0;
      w0 = acc_req && acc_mem && acc_wr && acc_addr == 8'h80;
      w1 = acc_req && acc_mem && acc_wr && acc_addr == 8'h84;
      // Writes to the present-state offset leave the model untouched
      if (acc_req && acc_mem && !acc_wr)
        rexp <= acc_addr == 8'h80 ? {16'h0000, e15, 10'h000, e4, 4'h0} :
          acc_addr == 8'h84 ? {16'h0000, m15, m14, 9'h000, m4, 4'h0} :
          acc_addr == 8'h88 ? {16'h0000, p15, 10'h000, p4, 4'h0} : 32'h00000000;
      e15 <= pend | (e15 & !func_rst & !(w0 & acc_wdata[15]));
      e4 <= wake_event | (e4 & !pme_status_clr & !(w0 & acc_wdata[4]));
      p4 <= wake_event | (p4 & !pme_status_clr & !(w0 & acc_wdata[4]));
      p15 <= pend & (m15 | !status_changed_option);
      m15 <= !func_rst & (w1 ? acc_wdata[15] : m15);
      m14 <= w1 ? acc_wdata[14] : m14;
      m4 <= w1 ? acc_wdata[4] : m4;
      armed <= armed | w0 | w1;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task complete_run;
    begin
      if (failures == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    i = $urandom(60817);
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    for (i = 0; i < 300; i = i + 1) begin
      @(posedge ref_clk);
      // Second power-up reset mid-run clears the wake and armed state
      resetn <= i != 150;
      status_changed_option <= $urandom % 4 != 0;
      main_status_bits <= 2'($urandom);
      power_state <= (i % 3 == 0) ? 2'($urandom) : 2'h0;
      wake_event <= $urandom % 4 == 0;
      pme_status_clr <= $urandom % 8 == 0;
      func_rst <= $urandom % 8 == 0;
      pme_status <= 1'($urandom);
      pme_enable <= i % 5 == 0;
      @(posedge ref_clk);
      resetn <= 1'b1;
      {wake_event, pme_status_clr, func_rst} <= 3'h0;
      repeat (3) @(posedge ref_clk);
      #1;
      chk(int_n, !(pend & (status_changed_option & armed ? m15 : 1'b1)));
      chk(wake_out, (pme_enable & pme_status) | (status_changed_option & armed & m14 & m4 & e4));
      chk(regs_valid, status_changed_option & armed);
      mem = $urandom % 8 != 0;
      host.xfer(mem, 1'($urandom), 8'h80 + 8'(4 * ($urandom % 5)), $urandom, rd, ak);
      chk(ak, mem);
      if (mem && !acc_wr)
        chk(rd, rexp);
    end
    complete_run;
  end
endmodule // csc_regs_tb
bind csc_regs csc_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);
